// [verilog/spi_frame_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "spi_frame_defs.svh"

// Contract
// - Go set: start once transmit data waits
// - Run while data and go; clear stops
// - Variable mode: start/stop by go bit
// - Length field 3 to 32, reset 8
// - Received word zero padded to boundary
// - Transmit disable: buffer not drained, reset one
// - Receive byte swap on read when set
// - Transmit byte swap on write when set
// - Bit order: MSB or LSB first
// - Loopback feeds transmit bits to receiver
// - Receive disable: nothing is stored
// - Role bit: slave or master
// - Idle clock level while deselected
// - Phase picks drive and sample edges
// - Full duplex: one bit in per out
// - Master burst count per select, reset one
module spi_frame_ctrl
    import spi_frame_pkg::*;
#(
    parameter int HALF_DIV = `SCLK_HALF_CYC
)(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe_o,
    input  wire logic        cs_n_i,
    output logic             cs_n_o,
    output logic             cs_n_oe_o,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o
);

    // ****************************************
    // Parameter check
    // ****************************************
    // Below four cycles the two-stage synced data input misses the sample edge
    if (HALF_DIV < 4 || HALF_DIV > 65535) begin : g_bad_div
        $error("HALF_DIV out of range");
    end

    // ****************************************
    // Declarations
    // ****************************************
    logic [31:0] ctrl_r;
    logic [31:0] tx_data_r;
    logic [31:0] rx_data_r;
    logic        tx_valid_r;
    logic        rx_valid_r;
    mst_state_t  state_r;
    mst_state_t  state_nxt;
    logic [15:0] div_r;
    logic [6:0]  tog_r;
    logic [7:0]  units_left_r;
    logic        sclk_r;
    logic        sclk_prev_r;
    logic        cs_prev_r;

    logic [2:0]  pin_sync;
    logic        s_sclk;
    logic        s_cs_n;
    logic        s_sdi;

    logic [7:0]  burst_cnt;
    logic        var_go;
    logic        var_ena;
    logic [5:0]  len_raw;
    logic [5:0]  eff_len;
    logic        tx_dis;
    logic        rx_swap;
    logic        tx_swap;
    logic        lsb_first;
    logic        loopback;
    logic        rx_dis;
    logic        controller_role_select;
    logic        cpol;
    logic        cpha;

    logic        hit_tx;
    logic        hit_rx;
    logic        hit_stat;
    logic        hit_ctrl;
    logic        mapped;
    logic        apb_wait;
    logic        apb_done;
    logic        wr_tx;
    logic        rd_rx;
    logic [31:0] rx_view;
    logic [31:0] status_w;
    logic [31:0] rd_word;

    logic [31:0] class_mask;
    logic [31:0] tx_unit;
    logic        tx_take;
    logic        unit_avail;
    logic        rx_room;
    logic        stop_var;
    logic        start_ok;
    logic        div_hit;
    logic        m_tick;
    logic        tog_last;
    logic        m_load;
    logic        s_cs_act;
    logic        s_cs_fall;
    logic        s_rise;
    logic        s_fall;
    logic        s_load;
    logic        edge_any;
    logic        edge_rise;
    logic        load_w;
    logic        push_rx;
    logic        busy;

    shift_mode_t sh_mode;
    shift_cmd_t  sh_cmd;
    logic        sh_sdo;
    logic [31:0] sh_rx_word;
    logic        sh_done;

    function automatic logic [31:0] bswap(input logic [31:0] w);
        bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // ****************************************
    // Control fields
    // ****************************************
    assign burst_cnt  = ctrl_r[`CTRL_BURST_MSB:`CTRL_BURST_LSB];
    assign var_go     = ctrl_r[`CTRL_VAR_GO];
    assign var_ena    = ctrl_r[`CTRL_VAR_ENA];
    assign len_raw    = ctrl_r[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
    assign tx_dis     = ctrl_r[`CTRL_TX_DIS];
    assign rx_swap    = ctrl_r[`CTRL_RX_SWAP];
    assign tx_swap    = ctrl_r[`CTRL_TX_SWAP];
    assign lsb_first  = ctrl_r[`CTRL_LSB_FIRST];
    assign loopback   = ctrl_r[`CTRL_LOOPBACK];
    assign rx_dis     = ctrl_r[`CTRL_RX_DIS];
    assign controller_role_select = ctrl_r[`CTRL_ROLE_SEL];
    assign cpol       = ctrl_r[`CTRL_CPOL];
    assign cpha       = ctrl_r[`CTRL_CPHA];

    // Out-of-range lengths are clamped rather than left undefined
    assign eff_len = (len_raw < `LEN_MIN) ? `LEN_MIN :
                     (len_raw > `LEN_MAX) ? `LEN_MAX : len_raw;

    // ****************************************
    // APB slave
    // ****************************************
    assign hit_tx   = (paddr_i == `OFS_TX_DATA);
    assign hit_rx   = (paddr_i == `OFS_RX_DATA);
    assign hit_stat = (paddr_i == `OFS_STATUS);
    assign hit_ctrl = (paddr_i == `OFS_CTRL);
    assign mapped   = hit_tx | hit_rx | hit_stat | hit_ctrl;
    // One wait state: pready rises on the second access cycle
    assign apb_wait = psel_i & penable_i & ~pready_o;
    assign apb_done = psel_i & penable_i & pready_o;
    assign wr_tx    = apb_done & pwrite_i & hit_tx;
    assign rd_rx    = apb_done & ~pwrite_i & hit_rx;

    assign rx_view  = rx_swap ? bswap(rx_data_r) : rx_data_r;
    assign busy     = (state_r != ST_IDLE) | (~controller_role_select & s_cs_act);
    assign status_w = {29'h0000_0000, busy, rx_valid_r, tx_valid_r};
    assign rd_word  = hit_rx   ? rx_view :
                      hit_stat ? status_w :
                      hit_ctrl ? ctrl_r : 32'h0000_0000;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= apb_wait;
            pslverr_o <= apb_wait & ~mapped;
            prdata_o  <= (apb_wait & ~pwrite_i) ? rd_word : 32'h0000_0000;
        end
    end

    // Writes take effect at the completing edge only
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctrl_r <= `CTRL_RESET;
        end else if (apb_done & pwrite_i & hit_ctrl) begin
            ctrl_r <= pwdata_i & `CTRL_WR_MASK;
        end
    end

    // ****************************************
    // Transmit and receive holding words
    // ****************************************
    assign class_mask = (eff_len <= 6'd8)  ? 32'h0000_00FF :
                        (eff_len <= 6'd16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    // Whole 8/16/32-bit unit is taken, bits above the length never leave
    assign tx_unit    = tx_data_r & class_mask;
    // Disabled transmit path never drains the buffer
    assign tx_take    = ~tx_dis & tx_valid_r;
    assign push_rx    = sh_done & ~rx_dis;

    // A write or push in the same cycle as the drain keeps the flag set
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_valid_r <= 1'b0;
            tx_data_r  <= 32'h0000_0000;
            rx_valid_r <= 1'b0;
            rx_data_r  <= 32'h0000_0000;
        end else begin
            tx_valid_r <= wr_tx | (tx_valid_r & ~(load_w & tx_take));
            rx_valid_r <= push_rx | (rx_valid_r & ~rd_rx);
            if (wr_tx) begin
                tx_data_r <= tx_swap ? bswap(pwdata_i) : pwdata_i;
            end
            if (push_rx) begin
                rx_data_r <= sh_rx_word;
            end
        end
    end

    // ****************************************
    // Master sequencer
    // ****************************************
    // With transmit disabled, the go bit alone paces the stream, in variable mode only
    assign unit_avail = tx_dis ? (var_ena & var_go) : tx_valid_r;
    // Master holds off rather than overwrite an unread word
    assign rx_room    = ~(rx_valid_r & ~rx_dis);
    assign stop_var   = var_ena & ~var_go;
    assign start_ok   = unit_avail & (~var_ena | var_go);
    assign div_hit    = (div_r == 16'(HALF_DIV - 1));
    assign m_tick     = (state_r == ST_RUN) & div_hit;
    assign tog_last   = (tog_r == {eff_len, 1'b0} - 7'd1);
    assign m_load     = (state_r == ST_WAIT) & (state_nxt == ST_RUN);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (controller_role_select && start_ok) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!controller_role_select || stop_var) begin
                    state_nxt = ST_END;
                end else if (unit_avail && rx_room) begin
                    state_nxt = ST_RUN;
                end else if (var_ena && !unit_avail) begin
                    state_nxt = ST_END;
                end
            end
            ST_RUN: begin
                if (!controller_role_select || stop_var) begin
                    state_nxt = ST_END;
                end else if (m_tick && tog_last) begin
                    // Variable mode ignores the burst count
                    state_nxt = (!var_ena && units_left_r <= 8'h01) ? ST_END : ST_WAIT;
                end
            end
            ST_END: begin
                if (div_hit) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r      <= ST_IDLE;
            div_r        <= 16'h0000;
            tog_r        <= 7'h00;
            units_left_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            div_r   <= (state_r != state_nxt || div_hit) ? 16'h0000 : div_r + 16'd1;
            tog_r   <= m_load ? 7'h00 : (m_tick ? tog_r + 7'd1 : tog_r);
            if (state_r == ST_IDLE) begin
                units_left_r <= burst_cnt;
            end else if (m_tick && tog_last) begin
                units_left_r <= units_left_r - 8'd1;
            end
        end
    end

    // Clock rests at the idle level outside a unit
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sclk_r <= 1'b0;
        end else if (state_r != ST_RUN) begin
            sclk_r <= cpol;
        end else if (m_tick) begin
            sclk_r <= ~sclk_r;
        end
    end

    // ****************************************
    // Serial pin input synchronisers, data input shared by both roles
    // ****************************************
    spi_pin_sync #(
        .W       (3),
        .RST_VAL (3'b010)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     ({sclk_i, cs_n_i, sdi_i}),
        .sync_o    (pin_sync)
    );

    assign s_sclk = pin_sync[2];
    assign s_cs_n = pin_sync[1];
    assign s_sdi  = pin_sync[0];

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sclk_prev_r <= 1'b0;
            cs_prev_r   <= 1'b1;
        end else begin
            sclk_prev_r <= s_sclk;
            cs_prev_r   <= s_cs_n;
        end
    end

    assign s_cs_act  = ~s_cs_n;
    assign s_cs_fall = cs_prev_r & ~s_cs_n;
    assign s_rise    = s_sclk & ~sclk_prev_r;
    assign s_fall    = ~s_sclk & sclk_prev_r;
    assign s_load    = ~controller_role_select & (s_cs_fall | (sh_done & s_cs_act));

    // ****************************************
    // Shift engine
    // ****************************************
    assign edge_any  = controller_role_select ? m_tick : ((s_rise | s_fall) & s_cs_act);
    assign edge_rise = controller_role_select ? ~sclk_r : s_rise;
    assign load_w    = m_load | s_load;

    assign sh_mode.lsb_first = lsb_first;
    assign sh_mode.len       = eff_len;
    assign sh_cmd.load       = load_w;
    assign sh_cmd.word       = tx_take ? tx_unit : 32'h0000_0000;
    // Phase 0 samples on rising edges, phase 1 on falling
    assign sh_cmd.sample     = edge_any & (edge_rise ^ cpha);
    assign sh_cmd.shift      = edge_any & ~(edge_rise ^ cpha);
    assign sh_cmd.bit_in     = loopback ? sh_sdo :
                               (controller_role_select ? s_sdi : s_sdi);

    spi_bit_shifter u_shifter (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .mode_i    (sh_mode),
        .cmd_i     (sh_cmd),
        .sdo_o     (sh_sdo),
        .rx_word_o (sh_rx_word),
        .done_o    (sh_done)
    );

    // ****************************************
    // Pin registers
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sclk_o    <= 1'b0;
            sclk_oe_o <= 1'b0;
            cs_n_o    <= 1'b1;
            cs_n_oe_o <= 1'b0;
            sdo_o     <= 1'b0;
            sdo_oe_o  <= 1'b0;
        end else begin
            sclk_o    <= sclk_r;
            sclk_oe_o <= controller_role_select;
            cs_n_o    <= (state_nxt == ST_IDLE);
            cs_n_oe_o <= controller_role_select;
            sdo_o     <= sh_sdo & ~tx_dis;
            sdo_oe_o  <= controller_role_select | s_cs_act;
        end
    end

endmodule

`default_nettype wire

// [verilog/spi_frame_defs.svh]
`ifndef SPI_FRAME_DEFS_SVH
`define SPI_FRAME_DEFS_SVH

// Register byte addresses
`define OFS_TX_DATA     8'h00
`define OFS_RX_DATA     8'h04
`define OFS_STATUS      8'h08
`define OFS_CTRL        8'h10

// Control register reset and writable bits
`define CTRL_RESET      32'h0010_8100
`define CTRL_WR_MASK    32'h0FFF_F1FF

// Control field positions
`define CTRL_BURST_MSB  27
`define CTRL_BURST_LSB  20
`define CTRL_VAR_GO     19
`define CTRL_VAR_ENA    18
`define CTRL_LEN_MSB    17
`define CTRL_LEN_LSB    12
`define CTRL_TX_DIS     8
`define CTRL_RX_SWAP    7
`define CTRL_TX_SWAP    6
`define CTRL_LSB_FIRST  5
`define CTRL_LOOPBACK   4
`define CTRL_RX_DIS     3
`define CTRL_ROLE_SEL   2
`define CTRL_CPOL       1
`define CTRL_CPHA       0

// Status field positions
`define STAT_TX_FULL    0
`define STAT_RX_VALID   1
`define STAT_BUSY       2

// Length limits and serial clock half period in system clocks
`define LEN_MIN         6'd3
`define LEN_MAX         6'd32
`define SCLK_HALF_CYC   4

`endif

// [verilog/spi_frame_pkg.sv]
package spi_frame_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10,
        ST_END  = 2'b11
    } mst_state_t;

    typedef struct packed {
        logic       lsb_first;
        logic [5:0] len;
    } shift_mode_t;

    typedef struct packed {
        logic        load;
        logic [31:0] word;
        logic        shift;
        logic        sample;
        logic        bit_in;
    } shift_cmd_t;

endpackage

// [verilog/spi_pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module spi_pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)(
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= pin_i;
            sync_o <= meta_r;
        end
    end

endmodule

`default_nettype wire

// [verilog/spi_bit_shifter.sv]
`timescale 1ns/100ps
`default_nettype none

module spi_bit_shifter
    import spi_frame_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire shift_mode_t mode_i,
    input  wire shift_cmd_t  cmd_i,
    output logic             sdo_o,
    output logic [31:0]      rx_word_o,
    output logic             done_o
);

    logic [31:0] tx_sh_r;
    logic [31:0] rx_sh_r;
    logic [5:0]  cnt_r;
    logic [31:0] len_mask;
    logic [31:0] rx_nxt;
    logic [31:0] tx_nxt;
    logic [5:0]  top_idx;
    logic        last_bit;

    assign top_idx   = mode_i.len - 6'd1;
    assign len_mask  = 32'hFFFF_FFFF >> (6'd32 - mode_i.len);
    assign last_bit  = (cnt_r == top_idx);
    // Bit order applies alike to both directions
    assign sdo_o     = mode_i.lsb_first ? tx_sh_r[0] : tx_sh_r[top_idx[4:0]];
    assign rx_nxt    = mode_i.lsb_first ?
                       ((rx_sh_r >> 1) | ({31'h0000_0000, cmd_i.bit_in} << top_idx)) :
                       {rx_sh_r[30:0], cmd_i.bit_in};
    assign tx_nxt    = mode_i.lsb_first ? (tx_sh_r >> 1) : (tx_sh_r << 1);
    // Upper bits stay zero up to the word boundary
    assign rx_word_o = rx_nxt & len_mask;
    assign done_o    = cmd_i.sample & last_bit;

    // One bit in per bit out; first bit is preset by the load
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_sh_r <= 32'h0000_0000;
            rx_sh_r <= 32'h0000_0000;
            cnt_r   <= 6'h00;
        end else if (cmd_i.load) begin
            tx_sh_r <= cmd_i.word;
            rx_sh_r <= 32'h0000_0000;
            cnt_r   <= 6'h00;
        end else begin
            if (cmd_i.sample) begin
                rx_sh_r <= rx_nxt;
                cnt_r   <= last_bit ? 6'h00 : cnt_r + 6'd1;
            end
            if (cmd_i.shift && cnt_r != 6'h00) begin
                tx_sh_r <= tx_nxt;
            end
        end
    end

endmodule

`default_nettype wire

// [verification/spi_frame_ctrl_checker.sv]
`timescale 1ns/100ps
`default_nettype none
`include "spi_frame_defs.svh"

module spi_frame_ctrl_checker #(
    parameter int HALF_DIV = 4
)(
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        sclk_o,
    input wire logic        sclk_oe_o,
    input wire logic        cs_n_o,
    input wire logic        cs_n_oe_o,
    input wire logic        sdo_o
);
    // ****************************************
    // Control shadow from committed writes
    // ****************************************
    logic [31:0] ctrl_r;
    logic [2:0]  quiet_r;
    wire logic   done_w  = psel_i && penable_i && pready_o;
    wire logic   wr_ctrl = done_w && pwrite_i && paddr_i == `OFS_CTRL;
    wire logic   map_w   = paddr_i == `OFS_TX_DATA || paddr_i == `OFS_RX_DATA
                           || paddr_i == `OFS_STATUS || paddr_i == `OFS_CTRL;
    // Pins lag a control write by a few cycles, so pin checks wait it out
    wire logic   quiet_w = quiet_r == 3'h7;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctrl_r  <= `CTRL_RESET;
            quiet_r <= 3'h7;
        end else if (wr_ctrl) begin
            ctrl_r  <= pwdata_i & `CTRL_WR_MASK;
            quiet_r <= 3'h0;
        end else if (!quiet_w) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    pready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready held past one cycle");
    pready_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("pready not in second access cycle");
    slverr_map_a: assert property (pready_o |-> pslverr_o == !map_w)
        else $error("error response wrong for address");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer cycle");
    ctrl_read_a: assert property (done_w && !pwrite_i && paddr_i == `OFS_CTRL |-> prdata_o == ctrl_r)
        else $error("control readback mismatch");
    idle_clock_a: assert property (sclk_oe_o && cs_n_o && quiet_w |-> sclk_o == ctrl_r[1])
        else $error("idle clock level wrong");
    role_pins_a: assert property (quiet_w |-> sclk_oe_o == ctrl_r[2] && cs_n_oe_o == ctrl_r[2])
        else $error("pin drive does not follow role");
    tx_zero_a: assert property (!cs_n_o && sclk_oe_o && ctrl_r[8] && quiet_w |-> !sdo_o)
        else $error("data sent while transmit disabled");
    go_stop_a: assert property (wr_ctrl && pwdata_i[2] && pwdata_i[18] && !pwdata_i[19] |-> ##[1:8] cs_n_o)
        else $error("select held after go cleared");

    cover property (wr_ctrl && pwdata_i[19]);
    cover property ($fell(cs_n_o));
    cover property (pready_o && pslverr_o);
endmodule
`default_nettype wire

// [verification/spi_frame_peer.sv]
`timescale 1ns/100ps
`default_nettype none

module spi_frame_peer (
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        sdo_i,
    input  wire logic        cpha_i,
    input  wire logic [31:0] reply_i,
    output logic             sdi_o,
    output logic [31:0]      cap_o,
    output int               cnt_o
);
    // ****************************************
    // Peripheral on the serial pins
    // ****************************************
    logic [31:0] rep_r = 32'h0;
    // Deselected, the line shows the inverse of its last bit
    assign sdi_o = rep_r[31] ^ cs_n_i;
    always @(negedge cs_n_i) begin
        rep_r = reply_i;
        cap_o = 32'h0;
        cnt_o = 0;
    end
    // Idle clock taken as low; phase picks the sampling edge
    always @(sclk_i) begin
        if (!cs_n_i && (sclk_i ^ cpha_i)) begin // One bit in per bit out
            cap_o = {cap_o[30:0], sdo_i};
            cnt_o = cnt_o + 1;
        end else if (!cs_n_i && cnt_o > 0) begin // First bit stands until one is taken
            rep_r = {rep_r[30:0], 1'h0};
        end
    end
endmodule
`default_nettype wire

// [verification/spi_frame_mode_config_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "spi_frame_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module spi_frame_mode_config_tb;
    logic        clk, rst, psel, penable, pwrite, cph, lsb, lp, txs, rxs, rxd, vm, serr;
    logic        ssclk = 1'h0, scs = 1'h1;
    logic [7:0]  paddr, sp, sg;
    logic [5:0]  ln;
    logic [31:0] pwdata, rdat, reply, w, tw, rv, ex, r;
    logic [31:0] seed = 32'h3401;
    logic [5:0]  lens [5] = '{6'h3, 6'h8, 6'hC, 6'h10, 6'h20};
    wire logic [31:0] prdata, cap;
    wire logic   pready, pslverr, sclk, sclk_oe, cs_n, cs_n_oe, sdo, sdo_oe, sdi;
    int          err_total, checked, cnt;

    spi_frame_ctrl #(.HALF_DIV(4)) spi_frame_ctrl_inst (
        .sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sclk_i(ssclk), .sclk_o(sclk),
        .sclk_oe_o(sclk_oe), .cs_n_i(scs), .cs_n_o(cs_n), .cs_n_oe_o(cs_n_oe),
        .sdi_i(scs ? sdi : sp[7]), .sdo_o(sdo), .sdo_oe_o(sdo_oe));
    spi_frame_peer spi_frame_peer_inst (.sclk_i(sclk), .cs_n_i(cs_n), .sdo_i(sdo),
        .cpha_i(cph), .reply_i(reply), .sdi_o(sdi), .cap_o(cap), .cnt_o(cnt));

    // ****************************************
    // Expectations and bus cycles
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Low n bits in wire order; mirrored when sent least significant first
    function automatic logic [31:0] ordr(input logic [31:0] x, input int n, input logic l);
        ordr = 32'h0;
        for (int i = 0; i < n; i++)
            ordr[l ? n - 1 - i : i] = x[i];
    endfunction
    function automatic logic [31:0] sw(input logic [31:0] x);
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wait_frame(input int n);
        int k;
        k = 0;
        while (cs_n !== 1'h0 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        while (cs_n !== 1'h1 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        `CHK("bit count", n, cnt)
    endtask
    task automatic stop_test();
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        stop_test();
    end
    initial begin
        {rst, psel, penable, pwrite, cph, paddr, pwdata, reply} = {5'h10, 8'h0, 64'h0};
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        `CHK("master pins", 1'h0, sclk_oe | cs_n_oe)
        apb(1'h0, `OFS_CTRL, 32'h0);
        `CHK("ctrl reset", `CTRL_RESET, rdat)
        apb(1'h0, 8'h0C, 32'h0);
        `CHK("unmapped", 1'h1, serr)
        for (int i = 0; i < 14; i++) begin
            r = rnd();
            ln = (i < 5) ? lens[i] : 6'(6'h3 + r[31:24] % 8'h1E);
            {vm, rxd, rxs, txs, lsb, cph} = r[5:0];
            lp = r[6];
            apb(1'h1, `OFS_CTRL, {4'h0, 8'h01, vm, vm, ln, 4'h0, rxs, txs, lsb, lp, rxd, 2'h2, cph});
            w = rnd();
            reply = rnd();
            apb(1'h1, `OFS_TX_DATA, w);
            wait_frame(ln);
            tw = txs ? sw(w) : w;
            ex = ordr(tw, ln, lsb);
            `CHK("sdo bits", ex, cap)
            rv = lp ? ordr(tw, ln, 1'h0) : ordr(reply >> (32 - ln), ln, lsb);
            apb(1'h0, `OFS_STATUS, 32'h0);
            ex = {30'h0, ~rxd, 1'h0};
            `CHK("status", ex, rdat)
            if (!rxd) begin
                apb(1'h0, `OFS_RX_DATA, 32'h0);
                ex = rxs ? sw(rv) : rv;
                `CHK("rx word", ex, rdat)
            end
        end
        apb(1'h1, `OFS_CTRL, 32'h0000_0106);
        apb(1'h1, `OFS_TX_DATA, 32'hFFFF_FFFF);
        repeat (20) @(posedge clk);
        `CHK("idle clock", 1'h1, sclk)
        `CHK("no start", 1'h1, cs_n)
        apb(1'h1, `OFS_CTRL, 32'hFFFF_FFFF);
        repeat (100) @(posedge clk);
        `CHK("stream", 1'h0, cs_n)
        apb(1'h0, `OFS_CTRL, 32'h0);
        `CHK("ctrl mask", `CTRL_WR_MASK, rdat)
        apb(1'h1, `OFS_CTRL, 32'h0004_0104);
        repeat (8) @(posedge clk);
        `CHK("stopped", 1'h1, cs_n)
        apb(1'h0, `OFS_STATUS, 32'h0);
        `CHK("tx kept", 1'h1, rdat[0])
        apb(1'h1, `OFS_CTRL, 32'h0010_8000);
        apb(1'h1, `OFS_TX_DATA, reply);
        {scs, sp} <= {1'h0, w[7:0]};
        for (int b = 0; b < 8; b++) begin
            repeat (8) @(posedge clk);
            ssclk <= 1'h1;
            sg = {sg[6:0], sdo};
            repeat (8) @(posedge clk);
            {ssclk, sp} <= {1'h0, sp[6:0], 1'h0};
        end
        `CHK("slave oe", 1'h1, sdo_oe)
        `CHK("slave sdo", reply[7:0], sg)
        scs <= 1'h1;
        apb(1'h0, `OFS_RX_DATA, 32'h0);
        `CHK("slave rx", {24'h0, w[7:0]}, rdat)
        stop_test();
    end
endmodule

bind spi_frame_ctrl spi_frame_ctrl_checker #(.HALF_DIV(HALF_DIV)) spi_frame_ctrl_checker_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
    .cs_n_o(cs_n_o), .cs_n_oe_o(cs_n_oe_o), .sdo_o(sdo_o));
`default_nettype wire
